// ===== hc_sched_pkg.sv
// Purpose: shared constants of the schedule, time-out and read-pointer registers
// Assumes: 200 MHz register clock, 16-bit register address
// Notes:   offsets are byte addresses
package hc_sched_pkg;

  // register port widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [15:0] SCHED_FILL_OFS = 16'h0334;
  localparam logic [15:0] ASYNC_TMO_OFS  = 16'h0338;
  localparam logic [15:0] MEM_RDPTR_OFS  = 16'h033c;

  // schedule_fill_status fields
  localparam int unsigned ASYNC_FILL_BIT  = 0;
  localparam int unsigned PERIOD_FILL_BIT = 1;
  localparam int unsigned STREAM_FILL_BIT = 2;
  localparam logic [2:0]  FILL_RESET      = 3'h0;

  // async_done_timeout reset value
  localparam logic [31:0] TMO_RESET = 32'h0000_0000;

  // memory_read_pointer fields
  localparam int unsigned PTR_LSB   = 0;
  localparam int unsigned PTR_MSB   = 15;
  localparam int unsigned BANK_LSB  = 16;
  localparam int unsigned BANK_MSB  = 17;
  localparam logic [1:0]  BANK_RESET = 2'h0;
  localparam logic [15:0] PTR_RESET  = 16'h0000;

  // timing: one time-out unit is one millisecond
  localparam int unsigned CLK_KHZ  = 200000;
  localparam int unsigned TMO_UNIT_MS = 1;
  localparam int unsigned MS_CYCLES = TMO_UNIT_MS * CLK_KHZ;

  // walker states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_CHECK = 5'b00100,
    ST_EXEC  = 5'b01000,
    ST_NEXT  = 5'b10000
  } walk_state_t;

  // list codes presented to the descriptor fetch port
  typedef enum logic [1:0] {
    LIST_ASYNC  = 2'h0,
    LIST_PERIOD = 2'h1,
    LIST_STREAM = 2'h2
  } list_t;

endpackage : hc_sched_pkg

// ===== ms_timer.sv
// Purpose: millisecond down-counter for the async completion time-out
// Assumes: start is a one-cycle pulse, limit stable while running
// Notes:   a limit of zero never arms the timer
module ms_timer
  import hc_sched_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // control
  input  wire logic        start,
  input  wire logic        cancel,
  input  wire logic [31:0] limit,
  // status
  output logic             busy,
  output logic             expired
);

  localparam int unsigned PW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYC - 1);

  generate
    if (MS_CYC < 1) begin : g_bad
      $error("ms_timer: MS_CYC must be at least 1");
    end
  endgenerate

  logic [PW-1:0] pre_r;
  logic [31:0]   left_r;
  logic          tick;

  assign tick = busy && (pre_r == PRE_LAST);

  // millisecond prescaler, restarts with each arm
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= '0;
    end else if (ce) begin
      if (start || !busy || tick) pre_r <= '0;
      else                        pre_r <= pre_r + 1'b1;
    end
  end

  // whole milliseconds remaining; expiry is a single pulse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy    <= 1'b0;
      left_r  <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (cancel) begin
        busy <= 1'b0;
      end else if (start && limit != 32'h0000_0000) begin
        busy   <= 1'b1;
        left_r <= limit;
      end else if (tick) begin
        left_r <= left_r - 1'b1;
        if (left_r == 32'h0000_0001) begin
          busy    <= 1'b0;
          expired <= 1'b1;
        end
      end
    end
  end

endmodule : ms_timer

// ===== ptr_bank.sv
// Purpose: per-bank auto-incrementing read pointers for programmed reads
// Assumes: one load and one step per cycle at most of each
// Notes:   load beats step when both hit the same bank
module ptr_bank
  import hc_sched_pkg::*;
#(
  parameter int unsigned BANKS = 4,
  parameter int unsigned PTR_W = 16
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic                     ce,
  // start address load
  input  wire logic                     load,
  input  wire logic [$clog2(BANKS)-1:0] load_bank,
  input  wire logic [PTR_W-1:0]         load_val,
  // one read of a bank
  input  wire logic                     step,
  input  wire logic [$clog2(BANKS)-1:0] step_bank,
  output logic      [PTR_W-1:0]         step_addr,
  // register view of one bank, steered by its next-cycle select
  input  wire logic [$clog2(BANKS)-1:0] peek_bank,
  output logic      [PTR_W-1:0]         peek_ptr
);

  generate
    if (BANKS < 2 || BANKS > 4 || PTR_W < 1 || PTR_W > 16) begin : g_bad
      $error("ptr_bank: BANKS must be 2..4 and PTR_W 1..16");
    end
  endgenerate

  logic [PTR_W-1:0] ptr_r [BANKS];

  // one pointer per bank; writing one leaves the rest alone
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < BANKS; i++) ptr_r[i] <= '0;
    end else if (ce) begin
      for (int i = 0; i < BANKS; i++) begin
        if (load && load_bank == i[$clog2(BANKS)-1:0])
          ptr_r[i] <= load_val;
        else if (step && step_bank == i[$clog2(BANKS)-1:0])
          ptr_r[i] <= ptr_r[i] + 1'b1;
      end
    end
  end

  // registered outputs: address used by a read, and the register view
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      step_addr <= '0;
      peek_ptr  <= '0;
    end else if (ce) begin
      if (step) step_addr <= ptr_r[step_bank];
      // view of the pointer as it stands after this edge
      if (load && load_bank == peek_bank)      peek_ptr <= load_val;
      else if (step && step_bank == peek_bank) peek_ptr <= ptr_r[peek_bank] + 1'b1;
      else                                     peek_ptr <= ptr_r[peek_bank];
    end
  end

endmodule : ptr_bank

// ===== hc_sched_regs.sv
// Purpose: schedule-fill flags, async completion time-out and memory read
//          pointers of the host engine, with the descriptor list walker
// Assumes: all inputs synchronous to clock; bus strobes one cycle long,
//          never both at once; ce low freezes every register
// Notes:   read data stand in the cycle after the read strobe only;
//          a cleared fill flag is honoured at the next list boundary;
//          each pointer write also picks the bank that reads step
//
// Chosen here: the plain strobed port.
module hc_sched_regs
  import hc_sched_pkg::*;
#(
  parameter int unsigned DESC_COUNT = 32,
  parameter int unsigned BANKS      = 4,
  parameter int unsigned MS_CYC     = MS_CYCLES
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  // register port
  input  wire logic [ADDR_W-1:0]         reg_addr,
  input  wire logic [DATA_W-1:0]         reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [DATA_W-1:0]         reg_rdata,
  // descriptor header fetch
  output logic                           hdr_req,
  output logic      [1:0]                hdr_list,
  output logic      [$clog2(DESC_COUNT)-1:0] hdr_index,
  input  wire logic                      hdr_ack,
  input  wire logic                      hdr_valid,
  input  wire logic                      hdr_skip,
  // descriptor execution
  output logic                           exec_start,
  input  wire logic                      exec_done,
  // async completion and time-out interrupt
  input  wire logic                      async_done,
  input  wire logic                      tmo_irq_en,
  output logic                           tmo_irq,
  // programmed memory reads
  input  wire logic                      pio_rd,
  output logic      [15:0]               pio_addr,
  output logic      [1:0]                pio_bank,
  // walker status
  output logic                           walk_busy
);

  localparam int unsigned IW = $clog2(DESC_COUNT);
  localparam int unsigned BW = $clog2(BANKS);
  localparam logic [IW-1:0] IDX_LAST = IW'(DESC_COUNT - 1);

  generate
    if (DESC_COUNT < 2 || BANKS != 4) begin : g_bad
      $error("hc_sched_regs: DESC_COUNT must be >= 2 and BANKS 4");
    end
  endgenerate

  // the prescaler cannot count a millisecond of zero cycles
  generate
    if (MS_CYC < 1) begin : g_bad_ms
      $error("hc_sched_regs: MS_CYC must be at least 1");
    end
  endgenerate

  // address match helper, used by both strobes
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // next filled list above the given one, no wrapping; none gives 2'h3
  function automatic logic [1:0] next_list(input logic [2:0] fill,
                                           input logic [1:0] cur);
    logic [1:0] n;
    n = 2'h3;
    for (int k = 2; k >= 0; k--) begin
      if (fill[k] && k > int'(cur)) n = k[1:0];
    end
    next_list = n;
  endfunction : next_list

  // register state
  logic [2:0]        fill_r;
  logic [31:0]       tmo_r;
  logic [1:0]        bank_r;

  // walker state
  walk_state_t       state_r;
  walk_state_t       state_nxt;
  logic [1:0]        list_r;
  logic [IW-1:0]     idx_r;

  // strobes and decoded accesses
  logic              wr_fill;
  logic              wr_tmo;
  logic              wr_ptr;
  logic [DATA_W-1:0] rdata_r;

  // pointer view and the bank it follows after this edge
  logic [15:0]       peek_ptr;
  logic [1:0]        bank_nxt;

  // time-out plumbing
  logic              tmo_busy;
  logic              tmo_expired;
  logic              tmo_pend_r;

  // list choice for the walker
  logic [1:0]        first_list;
  logic [1:0]        after_list;

  // write decode
  always_comb begin
    wr_fill = 1'b0;
    wr_tmo  = 1'b0;
    wr_ptr  = 1'b0;
    if (reg_wr && hit(reg_addr, SCHED_FILL_OFS)) begin
      wr_fill = 1'b1;
    end else if (reg_wr && hit(reg_addr, ASYNC_TMO_OFS)) begin
      wr_tmo = 1'b1;
    end else if (reg_wr && hit(reg_addr, MEM_RDPTR_OFS)) begin
      wr_ptr = 1'b1;
    end
  end

  // fill flags: plain read/write, zero after reset
  // reserved bits are not stored, so they read back zero
  // hardware never clears them; software owns every change
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fill_r <= FILL_RESET;
    end else if (ce && wr_fill) begin
      fill_r <= {reg_wdata[STREAM_FILL_BIT],
                 reg_wdata[PERIOD_FILL_BIT],
                 reg_wdata[ASYNC_FILL_BIT]};
    end
  end

  // time-out value in milliseconds
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tmo_r <= TMO_RESET;
    end else if (ce && wr_tmo) begin
      tmo_r <= reg_wdata;
    end
  end

  // bank select field, kept for register read-back and for reads
  // a write always names a bank, so selecting one also reloads it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bank_r <= BANK_RESET;
    end else if (ce && wr_ptr) begin
      bank_r <= reg_wdata[BANK_MSB:BANK_LSB];
    end
  end

  // the view port is steered to the bank of the coming cycle, so the
  // registered view already matches a bank chosen by this very write
  assign bank_nxt = wr_ptr ? reg_wdata[BANK_MSB:BANK_LSB] : bank_r;

  // pointer store: a write loads the chosen bank, a read steps it
  ptr_bank #(
    .BANKS (BANKS),
    .PTR_W (16)
  ) u_ptr (
    .clock     (clock),
    .rst_b     (rst_b),
    .ce        (ce),
    .load      (wr_ptr),
    .load_bank (reg_wdata[BANK_MSB:BANK_LSB]),
    .load_val  (reg_wdata[PTR_MSB:PTR_LSB]),
    .step      (pio_rd),
    .step_bank (bank_r[BW-1:0]),
    .step_addr (pio_addr),
    .peek_bank (bank_nxt[BW-1:0]),
    .peek_ptr  (peek_ptr)
  );

  // bank of the current programmed read, registered with the address
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pio_bank <= BANK_RESET;
    end else if (ce && pio_rd) begin
      pio_bank <= bank_r;
    end
  end

  // read decode; every answer is registered, the pointer word included,
  // since the view already tracks loads and steps of the selected bank
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      rdata_r <= 32'h0000_0000;
      if (reg_rd && hit(reg_addr, SCHED_FILL_OFS)) begin
        rdata_r <= {29'h0, fill_r};
      end else if (reg_rd && hit(reg_addr, ASYNC_TMO_OFS)) begin
        rdata_r <= tmo_r;
      end else if (reg_rd && hit(reg_addr, MEM_RDPTR_OFS)) begin
        rdata_r <= {14'h0, bank_r, peek_ptr};
      end
    end
  end

  // answer only in the cycle after the strobe; unmapped reads give zero
  assign reg_rdata = rdata_r;

  // list selection: lowest filled list first, then upward; 2'h3 means
  // nothing is left to walk
  always_comb begin
    if (fill_r[ASYNC_FILL_BIT]) begin
      first_list = LIST_ASYNC;
    end else begin
      first_list = next_list(fill_r, LIST_ASYNC);
    end
  end

  // successor of the list in hand, again from the live flags
  assign after_list = next_list(fill_r, list_r);

  // walker sequencing; one header at a time, so a slow header store or
  // a long execution simply stretches the walk, nothing is dropped
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (first_list != 2'h3) state_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        // the request stands until the header store answers
        if (hdr_ack) state_nxt = ST_CHECK;
      end
      ST_CHECK: begin
        // only valid headers not marked for skipping run
        if (hdr_valid && !hdr_skip) state_nxt = ST_EXEC;
        else                        state_nxt = ST_NEXT;
      end
      ST_EXEC: begin
        if (exec_done) state_nxt = ST_NEXT;
      end
      ST_NEXT: begin
        // the list in hand is finished even if its flag was just cleared
        if (idx_r != IDX_LAST)        state_nxt = ST_FETCH;
        else if (after_list != 2'h3)  state_nxt = ST_FETCH;
        else                          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // walker state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // current list and header index; a cleared flag drops its list
  // at the next list boundary, never in the middle of a descriptor
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      list_r <= LIST_ASYNC;
      idx_r  <= '0;
    end else if (ce) begin
      if (state_r == ST_IDLE && first_list != 2'h3) begin
        list_r <= first_list;
        idx_r  <= '0;
      end else if (state_r == ST_NEXT) begin
        if (idx_r != IDX_LAST) begin
          idx_r <= idx_r + 1'b1;
        end else begin
          idx_r <= '0;
          // with nothing left the code is kept, so an idle walker never
          // shows the no-list value on its fetch port
          if (after_list != 2'h3) begin
            list_r <= after_list;
          end
        end
      end
    end
  end

  // header fetch request holds until acknowledged
  // list and index come straight from registers
  assign hdr_req   = (state_r == ST_FETCH);
  assign hdr_list  = list_r;
  assign hdr_index = idx_r;
  assign walk_busy = (state_r != ST_IDLE);

  // execution start pulse on entry to the execute state
  // skipped or invalid headers never see this pulse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      exec_start <= 1'b0;
    end else if (ce) begin
      exec_start <= (state_r == ST_CHECK) && hdr_valid && !hdr_skip;
    end
  end

  // time-out runs from an async completion; other lists never arm it
  // a completion while the timer runs is ignored: it times the oldest
  ms_timer #(
    .MS_CYC (MS_CYC)
  ) u_tmo (
    .clock   (clock),
    .rst_b   (rst_b),
    .ce      (ce),
    .start   (async_done && !tmo_busy),
    .cancel  (wr_tmo),
    .limit   (tmo_r),
    .busy    (tmo_busy),
    .expired (tmo_expired)
  );

  // expiry is held until the enable drops or a new value is written;
  // a fresh expiry in the clearing cycle wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tmo_pend_r <= 1'b0;
    end else if (ce) begin
      if (tmo_expired)                 tmo_pend_r <= 1'b1;
      else if (wr_tmo || !tmo_irq_en)  tmo_pend_r <= 1'b0;
    end
  end

  // interrupt only while enabled
  // masking clears the pending bit, so no stale expiry fires later
  assign tmo_irq = tmo_pend_r && tmo_irq_en;

endmodule : hc_sched_regs

// ===== hc_sched_regs_asserts.sv
// Purpose: port-level checks of schedule flags, time-out and read pointers
// Assumes: ce held high by the environment
// Notes:   flag mirror rebuilt from bus writes, no internal probes
module hc_sched_regs_asserts
  import hc_sched_pkg::*;
#(
  parameter int unsigned DESC_COUNT = 32
) (
  // clock and reset
  input wire logic                          clock,
  input wire logic                          rst_b,
  // register port
  input wire logic [ADDR_W-1:0]             reg_addr,
  input wire logic [DATA_W-1:0]             reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [DATA_W-1:0]             reg_rdata,
  // descriptor walk
  input wire logic                          hdr_req,
  input wire logic [1:0]                    hdr_list,
  input wire logic [$clog2(DESC_COUNT)-1:0] hdr_index,
  input wire logic                          hdr_ack,
  input wire logic                          hdr_valid,
  input wire logic                          hdr_skip,
  input wire logic                          exec_start,
  input wire logic                          walk_busy,
  // time-out
  input wire logic                          async_done,
  input wire logic                          tmo_irq_en,
  input wire logic                          tmo_irq,
  // programmed reads
  input wire logic                          pio_rd,
  input wire logic [15:0]                   pio_addr,
  input wire logic [1:0]                    pio_bank
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic [2:0]  fill_m;
  logic        done_seen;
  logic [17:0] start_m;
  logic        fresh_m;

  // mirror of the flags; ce is not watched, so it must stay high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fill_m    <= 3'h0;
      done_seen <= 1'h0;
      start_m   <= 18'h0;
      fresh_m   <= 1'h0;
    end else begin
      if (reg_wr && reg_addr == SCHED_FILL_OFS) fill_m <= reg_wdata[2:0];
      if (async_done) done_seen <= 1'h1;
      // start of the latest pointer write, until the first read after it
      if (reg_wr && reg_addr == MEM_RDPTR_OFS) begin
        start_m <= reg_wdata[17:0];
        fresh_m <= 1'h1;
      end else if (pio_rd) begin
        fresh_m <= 1'h0;
      end
    end
  end

  chk_fill_read: assert property (reg_rd && reg_addr == SCHED_FILL_OFS |=>
    reg_rdata == {29'h0, fill_m}) else $error("fill flags read back wrong");
  chk_list_entry: assert property ($rose(hdr_req) && hdr_index == 0 |->
    hdr_list != 2'h3 && fill_m[hdr_list]) else $error("walk entered an empty list");
  chk_exec_hdr: assert property (exec_start |->
    $past(hdr_valid) && !$past(hdr_skip)) else $error("exec of invalid header");
  chk_req_hold: assert property (hdr_req && !hdr_ack |=>
    hdr_req && $stable(hdr_list) && $stable(hdr_index)) else $error("request dropped");
  chk_busy_walk: assert property (hdr_req || exec_start |-> walk_busy)
    else $error("walk busy low while walking");
  chk_ptr_load: assert property (pio_rd && fresh_m && !reg_wr |=>
    pio_addr == start_m[15:0] && pio_bank == start_m[17:16])
    else $error("first read not at start address");
  chk_ptr_step: assert property (pio_rd && !reg_wr ##1 pio_rd && !reg_wr |=>
    pio_addr == $past(pio_addr) + 16'h1 && $stable(pio_bank)) else $error("pointer not stepped");
  chk_irq_enable: assert property (tmo_irq |-> tmo_irq_en)
    else $error("interrupt while disabled");
  chk_irq_async: assert property ($rose(tmo_irq) |-> done_seen)
    else $error("time-out without async completion");

  cover property (exec_start);
  cover property ($rose(tmo_irq));
  cover property (pio_rd ##1 pio_rd);
  cover property (pio_rd && fresh_m);
endmodule : hc_sched_regs_asserts

bind hc_sched_regs hc_sched_regs_asserts #(.DESC_COUNT(DESC_COUNT)) u_hc_sched_regs_asserts (
  .clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hdr_req, .hdr_list,
  .hdr_index, .hdr_ack, .hdr_valid, .hdr_skip, .exec_start, .walk_busy, .async_done,
  .tmo_irq_en, .tmo_irq, .pio_rd, .pio_addr, .pio_bank);

// ===== hc_sched_regs_bench.sv
// Purpose: self-checking bench of schedule flags, time-out and read pointers
// Assumes: four descriptors a list, a four-cycle millisecond
// Notes:   ce held high; the bench plays software and descriptor memory
module hc_sched_regs_bench
  import hc_sched_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock = 1'h0;
  logic        rst_b = 1'h0;
  logic        ce = 1'h1;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [31:0] reg_rdata, v;
  logic        hdr_req, exec_start, tmo_irq, walk_busy;
  logic [1:0]  hdr_list, hdr_index, pio_bank;
  logic        hdr_ack = 1'h0;
  logic        hdr_valid = 1'h0;
  logic        hdr_skip = 1'h0;
  logic        exec_done = 1'h0;
  logic        async_done = 1'h0;
  logic        tmo_irq_en = 1'h0;
  logic        pio_rd = 1'h0;
  logic [15:0] pio_addr;
  int          fail_count = 0;
  int          cmp_count = 0;

  hc_sched_regs #(.DESC_COUNT(4), .BANKS(4), .MS_CYC(4)) u_hc_sched_regs (
    .clock, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hdr_req,
    .hdr_list, .hdr_index, .hdr_ack, .hdr_valid, .hdr_skip, .exec_start, .exec_done,
    .async_done, .tmo_irq_en, .tmo_irq, .pio_rd, .pio_addr, .pio_bank, .walk_busy);

  // 200 MHz clock
  always #2.5 clock = ~clock;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask : wr

  // data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [15:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
  endtask : rd

  // three back-to-back reads of the selected bank
  task pio(input logic [15:0] st, input logic [1:0] b);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      pio_rd <= (i < 3);
      #1;
      if (i > 0) begin
        check(pio_addr, 16'(st + i - 1));
        check(pio_bank, b);
      end
    end
  endtask : pio

  // serve one header fetch and judge whether it was run
  task desc(input logic [1:0] l, input logic [1:0] ix, input logic ok, input logic sk);
    int   k;
    logic got;
    k = 0;
    got = 1'h0;
    #1;
    while (hdr_req !== 1'h1 && k < 40) begin
      @(posedge clock);
      #1;
      k++;
    end
    check({hdr_req, hdr_list, hdr_index}, {1'h1, l, ix});
    @(posedge clock);
    hdr_ack <= 1'h1;
    hdr_valid <= ok;
    hdr_skip <= sk;
    @(posedge clock);
    hdr_ack <= 1'h0;
    repeat (4) begin
      @(posedge clock);
      #1;
      if (exec_start === 1'h1) got = 1'h1;
    end
    check(got, ok && !sk);
    if (got) begin
      @(posedge clock);
      exec_done <= 1'h1;
      async_done <= (l == 2'h0);
      @(posedge clock);
      exec_done <= 1'h0;
      async_done <= 1'h0;
    end
  endtask : desc

  task t_reset;
    rd(SCHED_FILL_OFS);
    check(v, {29'h0, FILL_RESET});
    rd(ASYNC_TMO_OFS);
    check(v, TMO_RESET);
    rd(MEM_RDPTR_OFS);
    check(v, {14'h0, BANK_RESET, PTR_RESET});
    rd(16'h0340);
    check(v, 32'h0);
    wr(ASYNC_TMO_OFS, 32'ha5c3_0f96);
    rd(ASYNC_TMO_OFS);
    check(v, 32'ha5c3_0f96);
    wr(ASYNC_TMO_OFS, 32'h1);
  endtask : t_reset

  // last bank starts near the top so its run wraps
  task t_ptr;
    for (int b = 0; b < 4; b++) begin
      wr(MEM_RDPTR_OFS, {14'h0, 2'(b), 2'(b), 14'h3ffe});
      rd(MEM_RDPTR_OFS);
      check(v, {14'h0, 2'(b), 2'(b), 14'h3ffe});
      pio({2'(b), 14'h3ffe}, 2'(b));
    end
  endtask : t_ptr

  task t_walk;
    @(posedge clock);
    tmo_irq_en <= 1'h1;
    wr(SCHED_FILL_OFS, 32'h2);
    for (int i = 0; i < 3; i++) desc(2'h1, 2'(i), i != 1, i == 2);
    wr(SCHED_FILL_OFS, 32'h5);
    rd(SCHED_FILL_OFS);
    check(v, 32'h5);
    desc(2'h1, 2'h3, 1'h1, 1'h0);
    for (int i = 0; i < 4; i++) desc(2'h2, 2'(i), 1'h1, 1'h0);
    check(tmo_irq, 1'h0);
    desc(2'h0, 2'h0, 1'h1, 1'h0);
    repeat (2) @(posedge clock);
    #1;
    check(tmo_irq, 1'h0);
    repeat (3) @(posedge clock);
    #1;
    check(tmo_irq, 1'h1);
    @(posedge clock);
    tmo_irq_en <= 1'h0;
    #1;
    check(tmo_irq, 1'h0);
    @(posedge clock);
    tmo_irq_en <= 1'h1;
    #1;
    check(tmo_irq, 1'h0);
    wr(SCHED_FILL_OFS, 32'h0);
    for (int i = 1; i < 4; i++) desc(2'h0, 2'(i), 1'h0, 1'h0);
    repeat (4) @(posedge clock);
    #1;
    check({walk_busy, hdr_req}, 2'h0);
  endtask : t_walk

  // main sequence after two cycles of reset
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'h1;
    t_reset;
    t_ptr;
    t_walk;
    complete_run;
  end

  // watchdog: the run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    fail_count++;
    complete_run;
  end
endmodule : hc_sched_regs_bench
